//--- capture_sink.sv
// Capture-side model: takes stream words and latches the I bus on the I/Q indicator.
// Assumes the sequencer's system clock and reset; the stall request comes from the bench.
module capture_sink
    import dual_adc_pkg::*;
(
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_stall,
    input  wire logic              i_valid,
    input  wire logic [PAIR_W-1:0] i_data,
    input  wire logic              i_iq_ind,
    input  wire logic [DATA_W-1:0] i_bus_i,
    output logic                   o_ready,
    output logic [PAIR_W-1:0]      o_last_word,
    output logic [DATA_W-1:0]      o_bus_word,
    output logic [15:0]            o_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic iq_prev_q;
    assign o_ready = !i_stall;
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            iq_prev_q   <= 1'b0;
            o_last_word <= '0;
            o_bus_word  <= '0;
            o_count     <= 16'h0000;
        end else begin
            iq_prev_q <= i_iq_ind;
            // Latch on indicator, not conversion clock
            if (i_iq_ind && !iq_prev_q) begin
                o_bus_word <= i_bus_i;
            end
            if (i_valid && o_ready) begin
                o_last_word <= i_data;
                o_count     <= o_count + 16'h0001;
            end
        end
    end
endmodule

//--- dual_adc_fifo.sv
// Word FIFO with registered output stage, valid/ready on both sides.
// Assumes writer and reader share the system clock.
module dual_adc_fifo
    import dual_adc_pkg::*;
#(
    parameter int unsigned WIDTH = PAIR_W,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_ce,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PTR_W:0]   cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, load;

    always_comb begin
        mem_d = mem_q;
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        ov_d  = ov_q;
        od_d  = od_q;
        push  = i_in_valid && (cnt_q != (PTR_W+1)'(DEPTH));
        load  = (!ov_q || i_out_ready) && (cnt_q != '0);
        if (ov_q && i_out_ready) begin
            ov_d = 1'b0;
        end
        if (load) begin
            od_d = mem_q[rd_q];
            ov_d = 1'b1;
            rd_d = PTR_W'(rd_q + 1'b1);
        end
        if (push) begin
            mem_d[wr_q] = i_in_data;
            wr_d        = PTR_W'(wr_q + 1'b1);
        end
        cnt_d = (PTR_W+1)'(cnt_q + push - load);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else if (i_ce) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_ce) begin
            mem_q <= mem_d;
        end
    end

    assign o_in_ready  = (cnt_q != (PTR_W+1)'(DEPTH));
    assign o_out_valid = ov_q;
    assign o_out_data  = od_q;
endmodule

//--- dual_adc_output_sequencer_tb.sv
// Self-checking bench for the converter output sequencer.
// Assumes 20 MHz system clock; conversion clock phases of 6 system cycles.
module dual_adc_output_sequencer_tb
    import dual_adc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, cclk, slp, idl, bsel, fsel, gain, stall, ready, valid, iq, act;
    logic [RAW_W-1:0] ri, rq;
    logic [DATA_W-1:0] bi, bq, bw, hi, hq;
    logic [PAIR_W-1:0] sd, lw;
    logic [15:0] cnt, c0;
    logic [DATA_W-1:0] ci [0:255];
    logic [DATA_W-1:0] cq [0:255];
    logic [RAW_W-1:0] tv [0:11];
    int n, num_errors, checks_done;
    bit mux_q, chk_on;

    dual_adc_seq uut (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_conv_clk(cclk),
        .i_sleep_request_pin(slp), .i_quick_idle_pin(idl), .i_bus_arrangement_select(bsel),
        .i_code_format_select(fsel), .i_gain_select(gain), .i_chan_i_raw(ri), .i_chan_q_raw(rq),
        .i_strm_ready(ready), .o_bus_i(bi), .o_bus_q(bq), .o_iq_ind(iq), .o_conv_active(act),
        .o_strm_valid(valid), .o_strm_data(sd));
    capture_sink sink (.i_sys_clk(clk), .i_nrst(nrst), .i_stall(stall), .i_valid(valid),
        .i_data(sd), .i_iq_ind(iq), .i_bus_i(bi), .o_ready(ready), .o_last_word(lw),
        .o_bus_word(bw), .o_count(cnt));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [DATA_W-1:0] clampv(input logic signed [RAW_W-1:0] v, input logic g);
        logic signed [RAW_W-1:0] s;
        s = g ? (v >>> 1) : v;
        if (s > RAW_POS_LIM) return POS_FS_TWOS;
        if (s < RAW_NEG_LIM) return NEG_FS_TWOS;
        return s[DATA_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] fmt(input logic [DATA_W-1:0] c);
        return fsel ? c : {~c[DATA_W-1], c[DATA_W-2:0]};
    endfunction

    task automatic chk(input logic [PAIR_W-1:0] got, input logic [PAIR_W-1:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic step(input logic [RAW_W-1:0] a, input logic [RAW_W-1:0] b);
        ri <= a;
        rq <= b;
        cclk <= 1'b0;
        repeat (6) @(posedge clk);
        if (chk_on && mux_q && n >= 3) begin
            chk(bi, fmt(cq[n-3]), "mux Q word");
            chk(iq, 1'b0, "indicator after fall");
        end
        ci[n] = clampv(a, gain);
        cq[n] = clampv(b, gain);
        cclk <= 1'b1;
        repeat (6) @(posedge clk);
        n++;
        if (chk_on && n >= 3) begin
            chk(bi, fmt(ci[n-3]), "I word");
            chk(bq, bsel ? fmt(cq[n-3]) : '0, "Q bus");
            chk(iq, 1'b1, "indicator after rise");
            chk(lw, {fmt(ci[n-3]), fmt(cq[n-3])}, "stream word");
            chk(bw, fmt(ci[n-3]), "indicator latch");
        end
        mux_q = !bsel;
    endtask

    task automatic hold(input logic [1:0] p);
        {slp, idl} <= p;
        repeat (6) @(posedge clk);
        hi = bi;
        hq = bq;
        // Frozen pipeline: per-step word checks do not apply
        chk_on = 0;
        repeat (2) step(12'h123, 12'h321);
        chk_on = 1;
        n -= 2;
        chk(act, 1'b0, "stopped");
        chk({bi, bq}, {hi, hq}, "held outputs");
        {slp, idl} <= 2'b00;
        repeat (8) @(posedge clk);
        chk(act, 1'b1, "running");
    endtask

    task automatic results();
        $display("Counts: %0d checks, %0d errors", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        num_errors++;
        results();
    end

    initial begin
        {nrst, cclk, slp, idl, bsel, fsel, gain, stall} = 8'h00;
        cclk = 1'b1;
        ri = '0;
        rq = '0;
        tv = '{12'h258, 12'hDA8, 12'hD44, 12'h005, 12'h064, 12'hF9C,
               12'h7FF, 12'h800, 12'h1FF, 12'hE00, 12'h44C, 12'hBB4};
        n = 0;
        mux_q = 0;
        chk_on = 1;
        repeat (6) @(posedge clk);
        chk({act, bi}, '0, "reset state");
        nrst <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            {bsel, fsel} <= m[1:0];
            gain <= m[0] ^ m[1];
            mux_q = 0;
            repeat (8) @(posedge clk);
            for (int k = 0; k < 6; k++) step(tv[2*k], tv[2*k+1]);
            $display("Mode %0d done", m);
        end
        for (int p = 1; p < 4; p++) begin
            hold(p[1:0]);
            repeat (3) step(tv[p], tv[p+6]);
        end
        $display("Power states done");
        stall <= 1'b1;
        chk_on = 0;
        c0 = cnt;
        repeat (22) step(tv[3], tv[4]);
        hi = bi;
        repeat (2) step(tv[5], tv[6]);
        chk(bi, hi, "stalled bus");
        chk(cnt, c0, "no take while stalled");
        stall <= 1'b0;
        repeat (60) @(posedge clk);
        chk(cnt - c0, PAIR_W'(FIFO_DEPTH + 1), "drained words");
        // Restart history; first words after resume are stale
        n = 0;
        mux_q = 0;
        chk_on = 1;
        repeat (5) step(tv[7], tv[8]);
        $display("Buffer test done");
        results();
    end
endmodule

//--- dual_adc_pkg.sv
// Shared constants and types for the dual-channel converter output sequencer.
// Assumes one system clock of 20 MHz; all pin timing is expressed in its cycles.
package dual_adc_pkg;

    localparam int unsigned DATA_W      = 10;
    localparam int unsigned RAW_W       = 12;
    localparam int unsigned PAIR_W      = 2 * DATA_W;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned PIN_COUNT   = 6;

    // Pin positions inside the synchroniser vector
    localparam int unsigned PIN_CONV_CLK = 0;
    localparam int unsigned PIN_SLEEP    = 1;
    localparam int unsigned PIN_IDLE     = 2;
    localparam int unsigned PIN_BUS_SEL  = 3;
    localparam int unsigned PIN_FMT_SEL  = 4;
    localparam int unsigned PIN_GAIN     = 5;

    // Timing
    localparam int unsigned SYS_CLK_NS         = 50;
    localparam int unsigned OUTPUT_VALID_DELAY_NS = 21;
    localparam int unsigned OUTPUT_VALID_DELAY_CYC =
        (OUTPUT_VALID_DELAY_NS / SYS_CLK_NS < 1) ? 1 : OUTPUT_VALID_DELAY_NS / SYS_CLK_NS;
    localparam int unsigned MAX_SAMPLE_RATE_MSPS = 30;

    // Full-scale codes, two's complement inside the pipeline
    localparam logic [DATA_W-1:0] POS_FS_TWOS = 10'h1FF;
    localparam logic [DATA_W-1:0] NEG_FS_TWOS = 10'h200;
    localparam logic [DATA_W-1:0] POS_FS_OFFS = 10'h3FF;
    localparam logic [DATA_W-1:0] NEG_FS_OFFS = 10'h000;
    localparam logic signed [RAW_W-1:0] RAW_POS_LIM = 12'sh1FF;
    localparam logic signed [RAW_W-1:0] RAW_NEG_LIM = -12'sh200;

    // Reset values
    localparam logic [DATA_W-1:0]    WORD_RST = 10'h000;
    localparam logic [PIN_COUNT-1:0] PINS_RST = 6'h00;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_IDLE  = 2'b01,
        ST_SLEEP = 2'b11
    } power_state_t;

endpackage

//--- dual_adc_seq.sv
// Dual-channel converter output sequencer: sampling, pipeline, clamp, format, bus modes.
// Assumes pins come from outside the system clock domain; raw samples come from same-clock logic.
// Operation
// - Sample I and Q together on falling edge
// - Parallel mode: I and Q on own buses
// - Mux mode: I after rise, Q after fall
// - Parallel latency is 2.5 clock cycles
// - Mux latency 2.5 for I, 3.0 for Q
// - Convert only with clock and pins low
// - Ten-bit result per channel, up to 30 MSPS; the 20 MHz pin sampling allows the code at most 10 MSPS
// - Below negative limit saturates negative full scale
// - Above positive limit saturates positive full scale
// - Select high parallel; low mux, Q low
// - Format low offset binary, high two's complement
// - Standby holds last conversion on outputs
// - Both pins high means sleep, outputs held
module dual_adc_seq
    import dual_adc_pkg::*;
(
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_nrst,
    input  wire logic                    i_ce,
    input  wire logic                    i_conv_clk,
    input  wire logic                    i_sleep_request_pin,
    input  wire logic                    i_quick_idle_pin,
    input  wire logic                    i_bus_arrangement_select,
    input  wire logic                    i_code_format_select,
    input  wire logic                    i_gain_select,
    input  wire logic signed [RAW_W-1:0] i_chan_i_raw,
    input  wire logic signed [RAW_W-1:0] i_chan_q_raw,
    input  wire logic                    i_strm_ready,
    output logic [DATA_W-1:0]            o_bus_i,
    output logic [DATA_W-1:0]            o_bus_q,
    output logic                         o_iq_ind,
    output logic                         o_conv_active,
    output logic                         o_strm_valid,
    output logic [PAIR_W-1:0]            o_strm_data
);

    // Clamp to range set by gain, result in two's complement
    function automatic logic [DATA_W-1:0] sat_word(input logic signed [RAW_W-1:0] raw,
                                                   input logic gain_hi);
        logic signed [RAW_W-1:0] v;
        v = gain_hi ? (raw >>> 1) : raw;
        if (v > RAW_POS_LIM) begin
            return POS_FS_TWOS;
        end else if (v < RAW_NEG_LIM) begin
            return NEG_FS_TWOS;
        end
        return v[DATA_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] fmt_word(input logic [DATA_W-1:0] v,
                                                   input logic twos);
        return twos ? v : {~v[DATA_W-1], v[DATA_W-2:0]};
    endfunction

    // Pin synchroniser
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] meta_q, sync_q;
    logic                 cclk_prev_q;

    assign pin_raw = {i_gain_select, i_code_format_select, i_bus_arrangement_select,
                      i_quick_idle_pin, i_sleep_request_pin, i_conv_clk};

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            meta_q      <= PINS_RST;
            sync_q      <= PINS_RST;
            cclk_prev_q <= 1'b0;
        end else if (i_ce) begin
            meta_q      <= pin_raw;
            sync_q      <= meta_q;
            cclk_prev_q <= sync_q[PIN_CONV_CLK];
        end
    end

    logic cclk_rise, cclk_fall, par_mode, twos_fmt, gain_hi;
    assign cclk_rise = sync_q[PIN_CONV_CLK] && !cclk_prev_q;
    assign cclk_fall = !sync_q[PIN_CONV_CLK] && cclk_prev_q;
    assign par_mode  = sync_q[PIN_BUS_SEL];
    assign twos_fmt  = sync_q[PIN_FMT_SEL];
    assign gain_hi   = sync_q[PIN_GAIN];

    // Power state
    power_state_t pwr_q, pwr_d;
    logic         act_q, act_d;

    always_comb begin
        unique case ({sync_q[PIN_SLEEP], sync_q[PIN_IDLE]})
            2'b00:        pwr_d = ST_RUN;
            2'b01:        pwr_d = ST_IDLE;
            2'b10, 2'b11: pwr_d = ST_SLEEP;
        endcase
        // Registered copy keeps the activity pin on a flop
        act_d = (pwr_d == ST_RUN);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            pwr_q <= ST_SLEEP;
            act_q <= 1'b0;
        end else if (i_ce) begin
            pwr_q <= pwr_d;
            act_q <= act_d;
        end
    end

    // Data path
    logic [DATA_W-1:0] s0_i_q, s0_q_q, s1_i_q, s1_q_q, s2_i_q, s2_q_q, qpend_q;
    logic [DATA_W-1:0] s0_i_d, s0_q_d, s1_i_d, s1_q_d, s2_i_d, s2_q_d, qpend_d;
    logic [DATA_W-1:0] bus_i_q, bus_i_d, bus_q_q, bus_q_d;
    logic              ind_q, ind_d;
    logic              fifo_ready, fifo_push;
    logic [PAIR_W-1:0] fifo_word;
    logic              conv_en;
    logic [DATA_W-1:0] samp_i_w, samp_q_w;

    assign samp_i_w = sat_word(i_chan_i_raw, gain_hi);
    assign samp_q_w = sat_word(i_chan_q_raw, gain_hi);
    // Full stream buffer pauses conversion rather than dropping words
    assign conv_en  = (pwr_q == ST_RUN) && fifo_ready;

    always_comb begin
        s0_i_d    = s0_i_q;
        s0_q_d    = s0_q_q;
        s1_i_d    = s1_i_q;
        s1_q_d    = s1_q_q;
        s2_i_d    = s2_i_q;
        s2_q_d    = s2_q_q;
        qpend_d   = qpend_q;
        bus_i_d   = bus_i_q;
        bus_q_d   = bus_q_q;
        ind_d     = ind_q;
        fifo_push = 1'b0;
        fifo_word = {fmt_word(s2_i_q, twos_fmt), fmt_word(s2_q_q, twos_fmt)};
        if (conv_en && cclk_fall) begin
            s0_i_d = samp_i_w;
            s0_q_d = samp_q_w;
            if (!par_mode) begin
                bus_i_d = fmt_word(qpend_q, twos_fmt);
            end
            ind_d = 1'b0;
        end
        if (conv_en && cclk_rise) begin
            s1_i_d  = s0_i_q;
            s1_q_d  = s0_q_q;
            s2_i_d  = s1_i_q;
            s2_q_d  = s1_q_q;
            bus_i_d = fmt_word(s2_i_q, twos_fmt);
            bus_q_d = par_mode ? fmt_word(s2_q_q, twos_fmt) : WORD_RST;
            qpend_d = s2_q_q;
            ind_d   = 1'b1;
            fifo_push = 1'b1;
        end
    end

    // Registers keep their last word whenever conversion is stopped
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            s0_i_q  <= WORD_RST;
            s0_q_q  <= WORD_RST;
            s1_i_q  <= WORD_RST;
            s1_q_q  <= WORD_RST;
            s2_i_q  <= WORD_RST;
            s2_q_q  <= WORD_RST;
            qpend_q <= WORD_RST;
            bus_i_q <= WORD_RST;
            bus_q_q <= WORD_RST;
            ind_q   <= 1'b0;
        end else if (i_ce) begin
            s0_i_q  <= s0_i_d;
            s0_q_q  <= s0_q_d;
            s1_i_q  <= s1_i_d;
            s1_q_q  <= s1_q_d;
            s2_i_q  <= s2_i_d;
            s2_q_q  <= s2_q_d;
            qpend_q <= qpend_d;
            bus_i_q <= bus_i_d;
            bus_q_q <= bus_q_d;
            ind_q   <= ind_d;
        end
    end

    dual_adc_fifo #(
        .WIDTH (PAIR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_nrst      (i_nrst),
        .i_ce        (i_ce),
        .i_in_valid  (fifo_push),
        .i_in_data   (fifo_word),
        .o_in_ready  (fifo_ready),
        .o_out_valid (o_strm_valid),
        .o_out_data  (o_strm_data),
        .i_out_ready (i_strm_ready)
    );

    assign o_bus_i       = bus_i_q;
    assign o_bus_q       = bus_q_q;
    assign o_iq_ind      = ind_q;
    assign o_conv_active = act_q;

    // Checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);

    a_sample_both_chan: assert property (i_ce && conv_en && cclk_fall |=>
        s0_i_q == $past(samp_i_w) && s0_q_q == $past(samp_q_w))
        else $error("channels not sampled together on falling edge");

    a_parallel_q_bus: assert property (i_ce && conv_en && cclk_rise && par_mode |=>
        o_bus_q == fmt_word($past(s2_q_q), $past(twos_fmt)) && o_iq_ind)
        else $error("parallel Q bus wrong after rising edge");

    a_mux_q_on_fall: assert property (i_ce && conv_en && cclk_fall && !par_mode |=>
        o_bus_i == fmt_word($past(qpend_q), $past(twos_fmt)) && !o_iq_ind)
        else $error("mux Q word not placed after falling edge");

    a_mux_q_lines_low: assert property (i_ce && conv_en && cclk_rise && !par_mode |=>
        o_bus_q == WORD_RST)
        else $error("Q lines not low in mux mode");

    a_pipe_advance: assert property (i_ce && conv_en && cclk_rise |=>
        s1_i_q == $past(s0_i_q) && s2_i_q == $past(s1_i_q) && o_bus_i == fmt_word($past(s2_i_q), $past(twos_fmt)))
        else $error("pipeline did not advance by one stage");

    a_hold_when_stopped: assert property (i_ce && pwr_q != ST_RUN |=>
        $stable(o_bus_i) && $stable(o_bus_q) && $stable(s2_i_q))
        else $error("outputs changed while stopped");

    a_sleep_priority: assert property (i_ce && sync_q[PIN_SLEEP] |=> pwr_q == ST_SLEEP ##1
        (!i_ce || !$past(sync_q[PIN_SLEEP]) || pwr_q == ST_SLEEP))
        else $error("sleep pin did not force sleep state");

    a_clamp_limits: assert property (i_ce && conv_en && cclk_fall && !gain_hi && i_chan_i_raw > RAW_POS_LIM |=>
        s0_i_q == POS_FS_TWOS)
        else $error("over-range input not clamped");

    a_format_full_scale: assert property (i_ce && conv_en && cclk_rise && s2_i_q == POS_FS_TWOS |=>
        o_bus_i == ($past(twos_fmt) ? 10'h1FF : 10'h3FF))
        else $error("full-scale code wrong for format");

    a_format_neg_scale: assert property (
        i_ce && conv_en && cclk_rise && s2_i_q == NEG_FS_TWOS
        |=> o_bus_i == ($past(twos_fmt) ? NEG_FS_TWOS : NEG_FS_OFFS))
        else $error("negative full-scale code wrong for format");

    // Range clamp at both gain settings
    a_neg_clamp_low: assert property (
        i_ce && conv_en && cclk_fall && !gain_hi && i_chan_i_raw < RAW_NEG_LIM
        |=> s0_i_q == NEG_FS_TWOS)
        else $error("under-range input not clamped at low gain");

    a_neg_clamp_high: assert property (
        i_ce && conv_en && cclk_fall && gain_hi && i_chan_q_raw < -12'sh400
        |=> s0_q_q == NEG_FS_TWOS)
        else $error("under-range input not clamped at high gain");

    a_pos_clamp_high: assert property (
        i_ce && conv_en && cclk_fall && gain_hi && i_chan_i_raw > 12'sh3FF
        |=> s0_i_q == POS_FS_TWOS)
        else $error("over-range input not clamped at high gain");

    a_qpend_track: assert property (
        i_ce && conv_en && cclk_rise
        |=> qpend_q == $past(s2_q_q))
        else $error("pending Q word not taken from last stage");

    a_par_fall_hold: assert property (
        i_ce && par_mode && cclk_fall
        |=> $stable(o_bus_i) && $stable(o_bus_q))
        else $error("parallel buses changed on falling edge");

    a_mux_fall_qlow: assert property (
        i_ce && !par_mode && cclk_fall
        |=> $stable(o_bus_q))
        else $error("Q lines changed on mux falling edge");

    // Activity follows the two low-power pins
    a_active_running: assert property (
        i_ce && !sync_q[PIN_SLEEP] && !sync_q[PIN_IDLE]
        |=> o_conv_active)
        else $error("not active with both pins low");

    a_inactive_stopped: assert property (
        i_ce && (sync_q[PIN_SLEEP] || sync_q[PIN_IDLE])
        |=> !o_conv_active)
        else $error("active while a low-power pin is high");

    a_sleep_no_sample: assert property (
        i_ce && pwr_q == ST_SLEEP
        |=> $stable(s0_i_q) && $stable(s0_q_q) && $stable(o_iq_ind))
        else $error("sample taken while asleep");

    c_parallel_word: cover property (i_ce && conv_en && cclk_rise && par_mode);
    c_mux_q_word:    cover property (i_ce && conv_en && cclk_fall && !par_mode);
    c_enter_sleep:   cover property (pwr_q == ST_RUN ##1 pwr_q == ST_SLEEP);
    c_fifo_full:     cover property (!fifo_ready);
    c_idle_hold:     cover property (pwr_q == ST_IDLE ##1 pwr_q == ST_IDLE);

endmodule
